// File: rtl/spr_port.v
// spr_port.v: pin roles, select modes and byte shifting of the serial port
// assumes pins arrive asynchronously; SCK idle low, data captured on rising edge
`timescale 1ns/1ps
`include "spr_defines.vh"
module spr_port (
  // clock and reset
  input wire MCLK_I,
  input wire RST_I,
  // control bits
  input wire PORT_ENABLE_BIT_I,
  input wire MASTER_ENABLE_BIT_I,
  input wire SELECT_MODE_HIGH_BIT_I,
  input wire SELECT_MODE_LOW_BIT_I,
  input wire FLAG_CLEAR_I,
  // transmit and receive data
  input wire [7:0] TX_DATA_I,
  input wire TX_LOAD_I,
  output reg [7:0] RX_DATA_O,
  // status
  output reg TRANSFER_COMPLETE_FLAG_O,
  output reg MODE_FAULT_FLAG_O,
  output reg MASTER_ACTIVE_O,
  output reg PORT_ACTIVE_O,
  output reg BUSY_O,
  // bus pins
  input wire MOSI_I,
  output reg MOSI_O,
  output reg MOSI_OE_O,
  input wire MISO_I,
  output reg MISO_O,
  output reg MISO_OE_O,
  input wire SCK_I,
  output reg SCK_O,
  output reg SCK_OE_O,
  input wire NSS_I,
  output reg NSS_O,
  output reg NSS_OE_O,
  output reg NSS_PIN_ROUTED_O
);
  wire [1:0] mode = {SELECT_MODE_HIGH_BIT_I, SELECT_MODE_LOW_BIT_I};
  wire mosi_s;
  wire miso_s;
  wire sck_s;
  wire sck_rise;
  wire sck_fall;
  wire nss_s;
  wire nss_fall;
  reg master_en;
  reg port_en;
  reg [7:0] shift;
  reg [`SPR_CNT_W-1:0] bit_cnt;
  reg [7:0] div_cnt;
  reg busy;
  reg sck_int;
  reg next_fault;
  reg fault_lock;
  reg miso_bit;
  wire selected;
  wire slave_mode;

  spr_sync #(.INIT(1'b0)) u_mosi (.clk_i(MCLK_I), .rst_i(RST_I), .din_i(MOSI_I),
    .sync_o(mosi_s), .rise_o(), .fall_o());
  spr_sync #(.INIT(1'b0)) u_miso (.clk_i(MCLK_I), .rst_i(RST_I), .din_i(MISO_I),
    .sync_o(miso_s), .rise_o(), .fall_o());
  spr_sync #(.INIT(1'b0)) u_sck (.clk_i(MCLK_I), .rst_i(RST_I), .din_i(SCK_I),
    .sync_o(sck_s), .rise_o(sck_rise), .fall_o(sck_fall));
  spr_sync #(.INIT(1'b1)) u_nss (.clk_i(MCLK_I), .rst_i(RST_I), .din_i(NSS_I),
    .sync_o(nss_s), .rise_o(), .fall_o(nss_fall));

  assign slave_mode = port_en & ~master_en;
  assign selected = (mode == `SPR_MODE_3WIRE) ? 1'b1 :
    ((mode == `SPR_MODE_4WIRE_IN) ? ~nss_s : 1'b1);

  always @* begin
    next_fault = port_en & master_en & (mode == `SPR_MODE_4WIRE_IN) & nss_fall;
  end

  always @(posedge MCLK_I) begin
    if (RST_I) begin
      master_en <= 1'b0;
      port_en <= 1'b0;
      MODE_FAULT_FLAG_O <= 1'b0;
      TRANSFER_COMPLETE_FLAG_O <= 1'b0;
      shift <= `SPR_RESET_BYTE;
      RX_DATA_O <= `SPR_RESET_BYTE;
      bit_cnt <= {`SPR_CNT_W{1'b0}};
      div_cnt <= 8'h00;
      busy <= 1'b0;
      sck_int <= 1'b0;
      fault_lock <= 1'b0;
      miso_bit <= 1'b0;
    end else begin
      // enables follow software unless a fault knocked them down
      if (next_fault) begin
        master_en <= 1'b0;
        port_en <= 1'b0;
        fault_lock <= 1'b1;
      end else if (fault_lock) begin
        // held down until software drops the port enable
        master_en <= 1'b0;
        port_en <= 1'b0;
        if (!PORT_ENABLE_BIT_I)
          fault_lock <= 1'b0;
      end else begin
        master_en <= MASTER_ENABLE_BIT_I;
        port_en <= PORT_ENABLE_BIT_I;
      end
      // set wins over clear
      if (next_fault)
        MODE_FAULT_FLAG_O <= 1'b1;
      else if (FLAG_CLEAR_I)
        MODE_FAULT_FLAG_O <= 1'b0;
      if (!port_en) begin
        // disabling is the only counter reset in three-wire slave
        bit_cnt <= {`SPR_CNT_W{1'b0}};
        busy <= 1'b0;
        sck_int <= 1'b0;
        div_cnt <= 8'h00;
        if (TX_LOAD_I)
          shift <= TX_DATA_I;
        if (FLAG_CLEAR_I)
          TRANSFER_COMPLETE_FLAG_O <= 1'b0;
      end else if (master_en) begin
        if (!busy) begin
          if (TX_LOAD_I) begin
            shift <= TX_DATA_I;
            busy <= 1'b1;
            bit_cnt <= {`SPR_CNT_W{1'b0}};
            div_cnt <= 8'h00;
          end
          if (FLAG_CLEAR_I)
            TRANSFER_COMPLETE_FLAG_O <= 1'b0;
        end else if (div_cnt == `SPR_HALF_DIV) begin
          div_cnt <= 8'h00;
          sck_int <= ~sck_int;
          if (!sck_int) begin
            miso_bit <= miso_s;
            bit_cnt <= bit_cnt + 1'b1;
          end else begin
            // shift on the fall so MOSI is steady at the far rise
            shift <= {shift[6:0], miso_bit};
            if (bit_cnt == `SPR_BYTE_BITS) begin
              busy <= 1'b0;
              RX_DATA_O <= {shift[6:0], miso_bit};
              TRANSFER_COMPLETE_FLAG_O <= 1'b1;
            end
          end
        end else begin
          div_cnt <= div_cnt + 8'h01;
          if (FLAG_CLEAR_I)
            TRANSFER_COMPLETE_FLAG_O <= 1'b0;
        end
      end else begin
        if ((mode == `SPR_MODE_4WIRE_IN) && nss_fall)
          bit_cnt <= {`SPR_CNT_W{1'b0}};
        else if (selected && sck_rise) begin
          shift <= {shift[6:0], mosi_s};
          if (bit_cnt == `SPR_BYTE_BITS - 4'h1) begin
            bit_cnt <= {`SPR_CNT_W{1'b0}};
            RX_DATA_O <= {shift[6:0], mosi_s};
            TRANSFER_COMPLETE_FLAG_O <= 1'b1;
          end else begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end else if (TX_LOAD_I && bit_cnt == {`SPR_CNT_W{1'b0}}) begin
          shift <= TX_DATA_I;
        end
        if (FLAG_CLEAR_I && !(selected && sck_rise && bit_cnt == `SPR_BYTE_BITS - 4'h1))
          TRANSFER_COMPLETE_FLAG_O <= 1'b0;
      end
    end
  end

  // pin drive, all registered
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      MOSI_O <= 1'b0;
      MOSI_OE_O <= 1'b0;
      MISO_O <= 1'b0;
      MISO_OE_O <= 1'b0;
      SCK_O <= 1'b0;
      SCK_OE_O <= 1'b0;
      NSS_O <= 1'b1;
      NSS_OE_O <= 1'b0;
      NSS_PIN_ROUTED_O <= 1'b0;
      MASTER_ACTIVE_O <= 1'b0;
      PORT_ACTIVE_O <= 1'b0;
      BUSY_O <= 1'b0;
    end else begin
      MOSI_O <= shift[7];
      MOSI_OE_O <= port_en & master_en;
      MISO_O <= shift[7];
      MISO_OE_O <= slave_mode & ((mode == `SPR_MODE_3WIRE) |
        ((mode == `SPR_MODE_4WIRE_IN) & ~nss_s) | mode[1]);
      SCK_O <= sck_int;
      SCK_OE_O <= port_en & master_en;
      NSS_O <= mode[1] ? mode[0] : 1'b1;
      NSS_OE_O <= mode[1];
      NSS_PIN_ROUTED_O <= (mode != `SPR_MODE_3WIRE);
      MASTER_ACTIVE_O <= master_en;
      PORT_ACTIVE_O <= port_en;
      BUSY_O <= busy;
    end
  end
endmodule

// File: rtl/spr_defines.vh
// spr_defines.vh: constants for the serial port pin-role block
// assumes inclusion by bare name from rtl modules
`ifndef SPR_DEFINES_VH
`define SPR_DEFINES_VH
`define SPR_MODE_3WIRE 2'h0
`define SPR_MODE_4WIRE_IN 2'h1
`define SPR_BYTE_BITS 4'h8
`define SPR_CNT_W 4
`define SPR_HALF_DIV 8'h0F
`define SPR_RESET_BYTE 8'h00
`endif

// File: rtl/spr_sync.v
// spr_sync.v: two-flop level synchroniser with edge flags
// assumes din is asynchronous to clk
`timescale 1ns/1ps
module spr_sync #(
  parameter INIT = 1'b0
) (
  input wire clk_i,
  input wire rst_i,
  input wire din_i,
  output reg sync_o,
  output wire rise_o,
  output wire fall_o
);
  reg stage;
  reg last;
  always @(posedge clk_i) begin
    if (rst_i) begin
      stage <= INIT;
      sync_o <= INIT;
      last <= INIT;
    end else begin
      stage <= din_i;
      sync_o <= stage;
      last <= sync_o;
    end
  end
  // edges seen only after second flop
  assign rise_o = sync_o & ~last;
  assign fall_o = ~sync_o & last;
endmodule

// File: bench/spr_port_assertions.sv
// spr_port_assertions.sv: pin-role checks on the serial port ports
// assumes binding onto spr_port, all sampled on MCLK_I
`timescale 1ns/1ps
module spr_port_chk (
  // clock, reset and controls
  input wire MCLK_I, RST_I, SELECT_MODE_HIGH_BIT_I, SELECT_MODE_LOW_BIT_I,
  // status
  input wire PORT_ACTIVE_O, MASTER_ACTIVE_O, MODE_FAULT_FLAG_O, TRANSFER_COMPLETE_FLAG_O, BUSY_O,
  // pin drivers
  input wire MOSI_OE_O, MISO_OE_O, SCK_OE_O, NSS_O, NSS_OE_O, NSS_PIN_ROUTED_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // windows of 3 or 4 cycles allow for the pin register stage
  chk_miso_off: assert property (!PORT_ACTIVE_O [*3] |-> !MISO_OE_O)
    else $error("miso driven while disabled");
  chk_master_pins: assert property ((MASTER_ACTIVE_O && PORT_ACTIVE_O) [*3]
    |-> MOSI_OE_O && SCK_OE_O && !MISO_OE_O) else $error("master pin roles wrong");
  chk_slave_pins: assert property ((PORT_ACTIVE_O && !MASTER_ACTIVE_O) [*3]
    |-> !MOSI_OE_O && !SCK_OE_O) else $error("slave drives mosi or sck");
  chk_3w_slave: assert property ((PORT_ACTIVE_O && !MASTER_ACTIVE_O &&
    !SELECT_MODE_HIGH_BIT_I && !SELECT_MODE_LOW_BIT_I) [*4] |-> MISO_OE_O)
    else $error("three-wire slave not driving miso");
  chk_nss_out: assert property ((SELECT_MODE_HIGH_BIT_I && $stable(SELECT_MODE_LOW_BIT_I)) [*4]
    |-> NSS_OE_O && NSS_O == SELECT_MODE_LOW_BIT_I) else $error("select output level wrong");
  chk_nss_in: assert property (!SELECT_MODE_HIGH_BIT_I [*4] |-> !NSS_OE_O)
    else $error("select driven in input mode");
  chk_nss_route: assert property ($stable({SELECT_MODE_HIGH_BIT_I, SELECT_MODE_LOW_BIT_I}) [*4]
    |-> NSS_PIN_ROUTED_O == (SELECT_MODE_HIGH_BIT_I | SELECT_MODE_LOW_BIT_I))
    else $error("select routing wrong");
  chk_fault_off: assert property ($rose(MODE_FAULT_FLAG_O)
    |-> ##[0:2] (!MASTER_ACTIVE_O && !PORT_ACTIVE_O)) else $error("fault left port enabled");
  chk_done_flag: assert property ($fell(BUSY_O) |-> ##[0:2] TRANSFER_COMPLETE_FLAG_O)
    else $error("no complete flag after byte");
endmodule
bind spr_port spr_port_chk chk (.*);

// File: bench/spr_far.sv
// spr_far.sv: behavioural far side of the bus, master or slave
// assumes the bench resolves line levels and feeds them back in
`timescale 1ns/1ps
module spr_far (
  // resolved lines
  input wire sck_i, mosi_i, miso_i,
  // far side drivers
  output reg sck_o = 1'b0, nss_o = 1'b1,
  output wire dat_o
);
  reg mst = 1'b0;
  reg [7:0] tx = 8'h00;
  reg [7:0] rx = 8'h00;
  assign dat_o = tx[7];
  // sample msb first on rising edge
  always @(posedge sck_i) rx <= {rx[6:0], mst ? miso_i : mosi_i};
  // inverted fill keeps a released line moving
  always @(negedge sck_i) tx <= {tx[6:0], ~tx[0]};
  // clock 160 ns, started well after select
  task xfer(input [7:0] b);
    integer i;
    begin
      tx = b;
      mst = 1'b1;
      #100;
      for (i = 0; i < 8; i = i + 1) begin
        #80 sck_o = 1'b1;
        #80 sck_o = 1'b0;
      end
      #100 mst = 1'b0;
    end
  endtask
endmodule

// File: bench/tb_spr_port.sv
// tb_spr_port.sv: self-checking bench for the serial port pin roles
// assumes spr_port, its checker and spr_far compiled first
`timescale 1ns/1ps
module tb_spr_port;
  reg clk = 1'b0, rst = 1'b1, en = 1'b0, men = 1'b0, mh = 1'b0, ml = 1'b0, fclr = 1'b0, txl = 1'b0;
  reg [7:0] txd = 8'h00, b, s;
  integer fails = 0, n_checks = 0, k, w;
  wire [7:0] rxd;
  wire flag, fault, mact, pact, busy, mo, mo_oe, mi, mi_oe, sk, sk_oe, ns, ns_oe, routed;
  wire f_sck, f_nss, f_dat;
  wire sck_w = sk_oe ? sk : f_sck;
  wire mosi_w = mo_oe ? mo : f_dat;
  wire miso_w = mi_oe ? mi : f_dat;
  wire nss_w = ns_oe ? ns : f_nss;
  spr_port uut (.MCLK_I(clk), .RST_I(rst), .PORT_ENABLE_BIT_I(en), .MASTER_ENABLE_BIT_I(men),
    .SELECT_MODE_HIGH_BIT_I(mh), .SELECT_MODE_LOW_BIT_I(ml), .FLAG_CLEAR_I(fclr),
    .TX_DATA_I(txd), .TX_LOAD_I(txl), .RX_DATA_O(rxd), .TRANSFER_COMPLETE_FLAG_O(flag),
    .MODE_FAULT_FLAG_O(fault), .MASTER_ACTIVE_O(mact), .PORT_ACTIVE_O(pact), .BUSY_O(busy),
    .MOSI_I(mosi_w), .MOSI_O(mo), .MOSI_OE_O(mo_oe), .MISO_I(miso_w), .MISO_O(mi),
    .MISO_OE_O(mi_oe), .SCK_I(sck_w), .SCK_O(sk), .SCK_OE_O(sk_oe), .NSS_I(nss_w),
    .NSS_O(ns), .NSS_OE_O(ns_oe), .NSS_PIN_ROUTED_O(routed));
  spr_far far (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(f_sck),
    .nss_o(f_nss), .dat_o(f_dat));
  function routed_exp(input h, input l);
    routed_exp = h | l;
  endfunction
  task cmp(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cfg(input e, input m, input h, input l);
    begin
      @(posedge clk);
      en <= e; men <= m; mh <= h; ml <= l; fclr <= 1'b1;
      @(posedge clk);
      fclr <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task load(input [7:0] d);
    begin
      txd <= d;
      txl <= 1'b1;
      @(posedge clk);
      txl <= 1'b0;
    end
  endtask
  // slave byte: far master clocks s in while b goes out
  task sx;
    begin
      b = $urandom;
      s = $urandom;
      // let a select fall clear a stale count before loading
      repeat (4) @(posedge clk);
      load(b);
      far.xfer(s);
      repeat (6) @(posedge clk);
    end
  endtask
  task summarize;
    begin
      if (fails == 0 && n_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial forever #2.5 clk = ~clk;
  initial begin
    #200000;
    fails = fails + 1;
    summarize;
  end
  initial begin
    k = $urandom(32'hD50E);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // master in three-wire, then select output low and high
    for (k = 0; k < 3; k = k + 1) begin
      b = $urandom;
      s = $urandom;
      cfg(1'b1, 1'b1, k != 0, k == 2);
      far.tx = s;
      load(b);
      repeat (4) @(posedge clk);
      for (w = 0; w < 600 && busy; w = w + 1) @(posedge clk);
      cmp(rxd, s);
      cmp(far.rx, b);
      cmp(flag, 1);
      cmp(routed, routed_exp(k != 0, k == 2));
      if (k != 0) cmp(ns, k == 2);
    end
    cfg(1'b1, 1'b0, 1'b0, 1'b1);
    far.nss_o <= 1'b0;
    sx;
    cmp(rxd, s);
    cmp(far.rx, b);
    cmp(mi_oe, 1);
    far.nss_o <= 1'b1;
    cfg(1'b1, 1'b0, 1'b0, 1'b1);
    cmp(mi_oe, 0);
    sx;
    cmp(flag, 0);
    cfg(1'b0, 1'b0, 1'b0, 1'b0);
    cmp(mi_oe, 0);
    // far model is the only other device on the bus
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    sx;
    cmp(rxd, s);
    cmp(far.rx, b);
    cfg(1'b1, 1'b1, 1'b0, 1'b1);
    far.nss_o <= 1'b0;
    repeat (10) @(posedge clk);
    cmp(fault, 1);
    cmp({mact, pact}, 0);
    summarize;
  end
endmodule
